//--- hw/tws_regs.svh
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// phase times as typical at the 10 MHz reference clock, in ns
`define TWS_REF_CLK_MHZ     10
`define TWS_T_LOW_NS        33000
`define TWS_T_HIGH_20K_NS   25800
`define TWS_T_HIGH_10K_NS   67800
`define TWS_T_HIGH_1K_NS    975000
`define TWS_T_LEAD_NS       91200
`define TWS_T_LAG_NS        81600

// rates scale with the clock, so a reference-clock time in ns maps to
// ns * ref_mhz / 1000 cycles at any clock rate
`define TWS_CYC(ns)         (((ns) * `TWS_REF_CLK_MHZ) / 1000)

// rate selector codes
`define TWS_RATE_1K         5'h01
`define TWS_RATE_10K        5'h0a
`define TWS_RATE_20K        5'h14

`define TWS_MAX_BITS        255
`define TWS_CNT_W           14

`endif

//--- hw/tws_pkg.sv
package tws_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_HIGH,
        ST_LOW,
        ST_LAG,
        ST_S_WAIT_ACT,
        ST_S_WAIT_IDLE
    } tws_state_t;

    typedef struct packed {
        logic       master;
        logic       invert;
        logic [4:0] rate;
        logic       sel_en;
        logic [2:0] sel_pin;
        logic       to_en;
        logic [2:0] to_pin;
        logic [7:0] count;
    } tws_cfg_t;

    typedef struct packed {
        logic [7:0] count;
        logic       timed_out;
    } tws_result_t;

endpackage

//--- hw/tws_sync.sv
`timescale 1ns/1ns
module tws_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    stage1[i] <= 1'b0;
                    sync_o[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_i[i];
                    sync_o[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

//--- hw/tws_bitbuf.sv
`timescale 1ns/1ns
module tws_bitbuf #(
    parameter int BYTES = 32,
    parameter int AW    = 5
) (
    input  wire logic          clock_i,
    input  wire logic          arst_n_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [7:0]    wr_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [7:0]    rd_data_o,
    input  wire logic [7:0]    tx_idx_i,
    output logic               tx_bit_o,
    input  wire logic          rx_we_i,
    input  wire logic [7:0]    rx_idx_i,
    input  wire logic          rx_bit_i
);
    logic [7:0] mem      [BYTES];
    logic [7:0] next_mem [BYTES];
    logic [7:0] next_rd_data;

    // bit indices reach byte 31 at most, and every byte needs an address
    if (BYTES < 1 || BYTES > 32 || BYTES > (1 << AW)) begin : g_bad_size
        $error("tws_bitbuf: BYTES does not fit the bit index or address");
    end

    // bit n of a transfer lives in byte n/8, msb first
    always_comb begin
        tx_bit_o     = mem[tx_idx_i[7:3]][3'h7 - tx_idx_i[2:0]];
        next_rd_data = mem[rd_addr_i];
    end

    generate
        for (genvar b = 0; b < BYTES; b++) begin : g_byte
            always_comb begin
                next_mem[b] = mem[b];
                if (wr_en_i && wr_addr_i == AW'(b)) begin
                    next_mem[b] = wr_data_i;
                end
                // the shifter wins over a concurrent byte load
                if (rx_we_i && rx_idx_i[7:3] == 5'(b)) begin
                    // untouched positions keep old data, so a short last byte is stale
                    next_mem[b][3'h7 - rx_idx_i[2:0]] = rx_bit_i;
                end
            end
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    mem[b] <= 8'h00;
                end else begin
                    mem[b] <= next_mem[b];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end
endmodule

//--- hw/tws_port.sv
// Operation
// - master drives clock, data out, data in
// - shift out and capture one bit per cycle
// - rising edge default, polarity option selects falling
// - any general pin serves as chip select
// - three selectable master bit rates, clock-scaled
// - select lead before first edge, lag after
// - fixed low phase, high phase rate-dependent
// - slave timeout pin high aborts transfer
// - slave drives bit, waits active, captures
// - slave waits idle, then next or finish
// - inverted option reverses tested slave clock levels
// - one to 255 bits per transfer
// - transmit bytes msb first from buffer
// - received bits overwrite buffer msb first
// - unfilled low bits of last byte undefined
// - busy from start until finish or abort
// - master select low before, high after
// - rate accepts 1, 10, 20; default 20
`timescale 1ns/1ns
`include "tws_regs.svh"
module tws_port
    import tws_pkg::*;
#(
    parameter int BUF_BYTES   = 32,
    parameter int HIGH_1K_CYC = `TWS_CYC(`TWS_T_HIGH_1K_NS)
) (
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    // requester side
    input  wire logic       start_i,
    input  wire tws_cfg_t   cfg_i,
    input  wire logic       buf_wr_en_i,
    input  wire logic [4:0] buf_wr_addr_i,
    input  wire logic [7:0] buf_wr_data_i,
    input  wire logic [4:0] buf_rd_addr_i,
    output logic      [7:0] buf_rd_data_o,
    output logic            busy_o,
    output logic            done_o,
    output tws_result_t     result_o,
    // pins
    input  wire logic       serial_clock_pin_i,
    output logic            serial_clock_pin_o,
    output logic            serial_clock_pin_oe_o,
    output logic            serial_out_pin_o,
    input  wire logic       serial_in_pin_i,
    input  wire logic [7:0] general_pins_i,
    output logic      [7:0] general_pins_o,
    output logic      [7:0] general_pins_oe_o
);
    localparam int CW = `TWS_CNT_W;

    // the buffer address is five bits wide, so at most 32 bytes
    if (BUF_BYTES < 1 || BUF_BYTES > 32) begin : g_bad_bytes
        $error("tws_port: BUF_BYTES must be 1..32");
    end
    if (HIGH_1K_CYC < 1 || HIGH_1K_CYC >= (1 << CW)) begin : g_bad_high
        $error("tws_port: HIGH_1K_CYC out of counter range");
    end
    // the fixed phases come from the header and must fit the down counter too
    if (`TWS_CYC(`TWS_T_LEAD_NS) >= (1 << CW)) begin : g_bad_lead
        $error("tws_port: lead count out of counter range");
    end
    if (`TWS_CYC(`TWS_T_LAG_NS) >= (1 << CW)) begin : g_bad_lag
        $error("tws_port: lag count out of counter range");
    end
    if (`TWS_CYC(`TWS_T_LOW_NS) >= (1 << CW)) begin : g_bad_low
        $error("tws_port: low count out of counter range");
    end
    if (`TWS_CYC(`TWS_T_HIGH_10K_NS) >= (1 << CW)) begin : g_bad_high10
        $error("tws_port: 10 kbps high count out of counter range");
    end
    if (`TWS_CYC(`TWS_T_HIGH_20K_NS) >= (1 << CW)) begin : g_bad_high20
        $error("tws_port: 20 kbps high count out of counter range");
    end
    // the bit index and the count are eight bits wide
    if (`TWS_MAX_BITS > 255) begin : g_bad_max
        $error("tws_port: transfer limit exceeds the eight-bit count");
    end

    localparam logic [CW-1:0] LOW_CYC      = CW'(`TWS_CYC(`TWS_T_LOW_NS));
    localparam logic [CW-1:0] HIGH_20K_CYC = CW'(`TWS_CYC(`TWS_T_HIGH_20K_NS));
    localparam logic [CW-1:0] HIGH_10K_CYC = CW'(`TWS_CYC(`TWS_T_HIGH_10K_NS));
    localparam logic [CW-1:0] HIGH_1K_C    = CW'(HIGH_1K_CYC);
    localparam logic [CW-1:0] LEAD_CYC     = CW'(`TWS_CYC(`TWS_T_LEAD_NS));
    localparam logic [CW-1:0] LAG_CYC      = CW'(`TWS_CYC(`TWS_T_LAG_NS));
    localparam logic [8:0]    BUF_BITS     = 9'(BUF_BYTES * 8);

    // pin inputs pass two flops before anything looks at them
    logic [9:0] pins_s;
    tws_sync #(.W(10)) u_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .async_i  ({serial_clock_pin_i, serial_in_pin_i, general_pins_i}),
        .sync_o   (pins_s)
    );
    logic sclk_s;
    logic sin_s;
    logic [7:0] gp_s;
    assign sclk_s = pins_s[9];
    assign sin_s  = pins_s[8];
    assign gp_s   = pins_s[7:0];

    tws_state_t    state;
    tws_state_t    next_state;
    tws_cfg_t      cfg;
    tws_cfg_t      next_cfg;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [7:0]    bit_idx;
    logic [7:0]    next_bit_idx;
    logic          sclk;
    logic          next_sclk;
    logic          sout;
    logic          next_sout;
    logic          cs_act;
    logic          next_cs_act;
    logic          done;
    logic          next_done;
    tws_result_t   result;
    tws_result_t   next_result;

    logic          rx_we;
    logic [7:0]    tx_idx;
    logic          tx_bit;
    logic          start_ok;
    logic          last_bit;
    logic          act_lvl;
    logic          to_hit;
    logic [CW-1:0] high_cyc;

    tws_bitbuf #(.BYTES(BUF_BYTES), .AW(5)) u_buf (
        .clock_i   (clock_i),
        .arst_n_i  (arst_n_i),
        .wr_en_i   (buf_wr_en_i),
        .wr_addr_i (buf_wr_addr_i),
        .wr_data_i (buf_wr_data_i),
        .rd_addr_i (buf_rd_addr_i),
        .rd_data_o (buf_rd_data_o),
        .tx_idx_i  (tx_idx),
        .tx_bit_o  (tx_bit),
        .rx_we_i   (rx_we),
        .rx_idx_i  (bit_idx),
        .rx_bit_i  (sin_s)
    );

    always_comb begin
        // zero counts and counts beyond the buffer are refused
        start_ok = start_i && cfg_i.count != 8'h00
                   && {1'b0, cfg_i.count} <= BUF_BITS;
        last_bit = bit_idx == cfg.count - 8'h01;
        // default active level high; inverted option swaps it
        act_lvl  = ~cfg.invert;
        to_hit   = cfg.to_en && gp_s[cfg.to_pin];
        // anything other than 1 or 10 runs at the 20 kbps setting
        unique case (cfg.rate)
            `TWS_RATE_1K:  high_cyc = HIGH_1K_C;
            `TWS_RATE_10K: high_cyc = HIGH_10K_CYC;
            default:       high_cyc = HIGH_20K_CYC;
        endcase
        // outside idle the next transmit bit is one ahead of the capture index; idle presents bit 0
        tx_idx   = (state == ST_IDLE) ? 8'h00 : bit_idx + 8'h01;
    end

    always_comb begin
        next_state   = state;
        next_cfg     = cfg;
        next_cnt     = cnt;
        next_bit_idx = bit_idx;
        next_sclk    = sclk;
        next_sout    = sout;
        next_cs_act  = cs_act;
        next_done    = 1'b0;
        next_result  = result;
        rx_we        = 1'b0;
        unique case (state)
            ST_IDLE: begin
                next_sclk = cfg.invert;
                if (start_ok) begin
                    next_cfg     = cfg_i;
                    next_bit_idx = 8'h00;
                    next_sout    = tx_bit;
                    if (cfg_i.master) begin
                        next_sclk   = cfg_i.invert;
                        next_cs_act = 1'b1;
                        next_cnt    = LEAD_CYC;
                        next_state  = ST_LEAD;
                    end else begin
                        // a slave clock already active here counts as the first edge
                        next_state  = ST_S_WAIT_ACT;
                    end
                end
            end
            ST_LEAD, ST_LOW: begin
                if (cnt <= 14'h0001) begin
                    // active edge: capture in the same cycle as the active clock level goes out
                    next_sclk  = act_lvl;
                    rx_we      = 1'b1;
                    next_cnt   = high_cyc;
                    next_state = ST_HIGH;
                end else begin
                    next_cnt = cnt - 14'h0001;
                end
            end
            ST_HIGH: begin
                if (cnt <= 14'h0001) begin
                    next_sclk = ~act_lvl;
                    if (last_bit) begin
                        next_cnt   = LAG_CYC;
                        next_state = ST_LAG;
                    end else begin
                        // new data goes out on the inactive edge
                        next_bit_idx = bit_idx + 8'h01;
                        next_sout    = tx_bit;
                        next_cnt     = LOW_CYC;
                        next_state   = ST_LOW;
                    end
                end else begin
                    next_cnt = cnt - 14'h0001;
                end
            end
            ST_LAG: begin
                if (cnt <= 14'h0001) begin
                    next_cs_act = 1'b0;
                    next_done   = 1'b1;
                    next_result = '{count: cfg.count, timed_out: 1'b0};
                    next_state  = ST_IDLE;
                end else begin
                    next_cnt = cnt - 14'h0001;
                end
            end
            ST_S_WAIT_ACT: begin
                if (sclk_s == act_lvl) begin
                    rx_we      = 1'b1;
                    next_state = ST_S_WAIT_IDLE;
                end else if (to_hit) begin
                    next_done   = 1'b1;
                    next_result = '{count: bit_idx, timed_out: 1'b1};
                    next_state  = ST_IDLE;
                end
            end
            ST_S_WAIT_IDLE: begin
                if (sclk_s == ~act_lvl) begin
                    if (last_bit) begin
                        next_done   = 1'b1;
                        next_result = '{count: cfg.count, timed_out: 1'b0};
                        next_state  = ST_IDLE;
                    end else begin
                        next_bit_idx = bit_idx + 8'h01;
                        next_sout    = tx_bit;
                        next_state   = ST_S_WAIT_ACT;
                    end
                end else if (to_hit) begin
                    // the bit captured in this round already counts
                    next_done   = 1'b1;
                    next_result = '{count: bit_idx + 8'h01, timed_out: 1'b1};
                    next_state  = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state   <= ST_IDLE;
            cfg     <= '0;
            cnt     <= '0;
            bit_idx <= 8'h00;
            sclk    <= 1'b0;
            sout    <= 1'b0;
            cs_act  <= 1'b0;
            done    <= 1'b0;
            result  <= '0;
        end else begin
            state   <= next_state;
            cfg     <= next_cfg;
            cnt     <= next_cnt;
            bit_idx <= next_bit_idx;
            sclk    <= next_sclk;
            sout    <= next_sout;
            cs_act  <= next_cs_act;
            done    <= next_done;
            result  <= next_result;
        end
    end

    // the select pin is driven only for a master with select enabled;
    // idle it stays driven high so the peripheral sees a clean frame
    always_comb begin
        general_pins_o    = 8'hff;
        general_pins_oe_o = 8'h00;
        if (cfg.master && cfg.sel_en) begin
            general_pins_oe_o[cfg.sel_pin] = 1'b1;
            general_pins_o[cfg.sel_pin]    = ~cs_act;
        end
    end

    assign serial_clock_pin_o    = sclk;
    assign serial_clock_pin_oe_o = cfg.master;
    assign serial_out_pin_o      = sout;
    assign busy_o                = state != ST_IDLE;
    assign done_o                = done;
    assign result_o              = result;
endmodule

//--- bench/tws_port_monitor.sv
`timescale 1ns/1ns
`include "tws_regs.svh"
module tws_port_monitor
    import tws_pkg::*;
#(
    parameter int HIGH_1K_CYC = 9750
) (
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    input wire logic        start_i,
    input wire tws_cfg_t    cfg_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire tws_result_t result_o,
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe_o,
    input wire logic [7:0]  general_pins_o,
    input wire logic [7:0]  general_pins_oe_o
);
    localparam int LEAD = `TWS_CYC(`TWS_T_LEAD_NS);
    localparam int LAG  = `TWS_CYC(`TWS_T_LAG_NS);
    localparam int LOW  = `TWS_CYC(`TWS_T_LOW_NS);
    tws_cfg_t    lat;
    logic [13:0] since;
    logic        first;
    logic        take;
    logic        act;
    logic        cs;
    logic        msel;
    int          high_exp;
    assign take = start_i && !busy_o && cfg_i.count != 8'h00;
    assign act  = serial_clock_pin_o ^ lat.invert;
    assign cs   = general_pins_o[lat.sel_pin];
    assign msel = lat.master && lat.sel_en;
    assign high_exp = (lat.rate == `TWS_RATE_1K) ? HIGH_1K_CYC :
                      (lat.rate == `TWS_RATE_10K) ? `TWS_CYC(`TWS_T_HIGH_10K_NS) :
                      `TWS_CYC(`TWS_T_HIGH_20K_NS);
    // settings judged are those of the accepted start, not the live port
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lat   <= '0;
            since <= '0;
            first <= 1'b0;
        end else begin
            if (take) lat <= cfg_i;
            if (take) first <= 1'b1;
            else if (act && busy_o) first <= 1'b0;
            if (take) since <= '0;
            else if ($changed(serial_clock_pin_o)) since <= 14'h0001;
            else if (since != 14'h3fff) since <= since + 14'h0001;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    property p_take; take |=> busy_o; endproperty
    a_take: assert property (p_take) else $error("start not taken");
    property p_done; done_o |-> !busy_o && $past(busy_o) ##1 !done_o; endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_hold; !done_o |-> $stable(result_o); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_cnt; done_o && !result_o.timed_out |-> result_o.count == lat.count; endproperty
    a_cnt: assert property (p_cnt) else $error("bit count wrong");
    property p_cs; busy_o && msel |-> general_pins_oe_o[lat.sel_pin] && !cs; endproperty
    a_cs: assert property (p_cs) else $error("select not low in frame");
    property p_csi; !busy_o && msel |-> cs; endproperty
    a_csi: assert property (p_csi) else $error("select not high when idle");
    property p_oe; busy_o |-> serial_clock_pin_oe_o == lat.master; endproperty
    a_oe: assert property (p_oe) else $error("clock pin direction wrong");
    property p_idle; !busy_o && lat.master |-> !act; endproperty
    a_idle: assert property (p_idle) else $error("clock idle level wrong");
    property p_rise; busy_o && lat.master && $rose(act) |-> since == (first ? LEAD : LOW);
    endproperty
    a_rise: assert property (p_rise) else $error("lead or low phase wrong");
    property p_fall; busy_o && lat.master && $fell(act) |-> since == high_exp; endproperty
    a_fall: assert property (p_fall) else $error("high phase wrong");
    property p_lag; msel && $rose(cs) |-> since == LAG; endproperty
    a_lag: assert property (p_lag) else $error("select lag wrong");
endmodule
bind tws_port tws_port_monitor #(.HIGH_1K_CYC(HIGH_1K_CYC)) u_mon (
    .clock_i, .arst_n_i, .start_i, .cfg_i, .busy_o, .done_o, .result_o,
    .serial_clock_pin_o, .serial_clock_pin_oe_o, .general_pins_o, .general_pins_oe_o
);

//--- bench/tws_far_end.sv
`timescale 1ns/1ns
module tws_far_end (
    input  wire logic  sclk_i,
    input  wire logic  invert_i,
    input  wire logic  sel_n_i,
    input  wire logic  din_i,
    output logic       sclk_o,
    output logic [0:0] dout_o,
    output logic [15:0] rx_o
);
    logic [15:0] sh;
    logic        cap;
    logic        act;
    assign act = sclk_i ^ invert_i;
    initial begin
        sclk_o = 1'b0;
        dout_o = 1'b0;
        sh = '0;
        rx_o = '0;
        cap = 1'b0;
    end
    // idle level first, so the level change cannot count as a bit
    task automatic arm(input logic [15:0] tx);
        // let the new polarity reach the port before the idle level is set
        #1;
        sclk_o = invert_i;
        #1;
        cap = 1'b0;
        rx_o = '0;
        sh = tx;
        dout_o = tx[15];
    endtask
    // clock only inside the burst, held at idle outside it
    task automatic burst(input int n);
        repeat (n) begin
            // 125 ns period, still several cycles per level for the synchroniser
            #63 sclk_o = ~invert_i;
            #62 sclk_o = invert_i;
        end
        dout_o = ~dout_o;
    endtask
    always @(posedge act) begin
        rx_o = {rx_o[14:0], din_i};
        cap = 1'b1;
    end
    // shift only after a capture, level changes between frames are ignored
    always @(negedge act) begin
        if (cap) begin
            sh = sh << 1;
            dout_o = sh[15];
            cap = 1'b0;
        end
    end
    always @(posedge sel_n_i) dout_o = ~dout_o;
endmodule

//--- bench/test_tws_port.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_tws_port
    import tws_pkg::*;
    ;
    logic        clock_i;
    logic        arst_n_i;
    logic        start_i;
    logic        wr_en;
    logic [4:0]  wa;
    logic [4:0]  ra;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [7:0]  gp_i;
    logic [7:0]  gp_o;
    logic [7:0]  gp_oe;
    logic [7:0]  gp_w;
    logic        busy;
    logic        done;
    logic        sck_o;
    logic        sck_oe;
    logic        sck_w;
    logic        sdo;
    logic        far_sck;
    logic        far_sdo;
    logic [15:0] far_rx;
    tws_cfg_t    cfg;
    tws_result_t res;
    int          n_errors;
    int          compares;
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    assign sck_w = sck_oe ? sck_o : far_sck;
    assign gp_w  = (gp_oe & gp_o) | (~gp_oe & gp_i);
    tws_port #(.HIGH_1K_CYC(400)) u_dut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .start_i(start_i), .cfg_i(cfg),
        .buf_wr_en_i(wr_en), .buf_wr_addr_i(wa), .buf_wr_data_i(wd),
        .buf_rd_addr_i(ra), .buf_rd_data_o(rd), .busy_o(busy), .done_o(done),
        .result_o(res), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_o(sck_oe), .serial_out_pin_o(sdo),
        .serial_in_pin_i(far_sdo), .general_pins_i(gp_w), .general_pins_o(gp_o),
        .general_pins_oe_o(gp_oe)
    );
    tws_far_end u_far (
        .sclk_i(sck_w), .invert_i(cfg.invert), .sel_n_i(gp_w[cfg.sel_pin]),
        .din_i(sdo), .sclk_o(far_sck), .dout_o(far_sdo), .rx_o(far_rx)
    );
    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask
    task automatic stop_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic tws_cfg_t mk(input logic m, input logic inv, input logic [4:0] r,
                                    input logic [7:0] n);
        mk = '{m, inv, r, m, 3'h3, ~m, 3'h6, n};
    endfunction
    task automatic wrb(input logic [4:0] a, input logic [7:0] d);
        wa = a;
        wd = d;
        wr_en = 1'b1;
        tick();
        wr_en = 1'b0;
        // an edge passes so a following write never re-raises the strobe at once
        tick();
    endtask
    task automatic chk_buf(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        ra = a;
        tick();
        `CHK("buffer", e & m, rd & m)
    endtask
    // second start while busy carries another count and must be ignored
    task automatic run(input tws_cfg_t c, input logic [15:0] tx, input int nb,
                       input logic abort, input logic [7:0] ecnt);
        int k;
        cfg = c;
        u_far.arm(tx);
        tick();
        start_i = 1'b1;
        tick();
        `CHK("busy", 1'b1, busy)
        cfg.count = ~c.count;
        tick();
        start_i = 1'b0;
        if (nb > 0) u_far.burst(nb);
        tick();
        gp_i[6] = abort;
        for (k = 0; k < 40000 && done !== 1'b1; k++) tick();
        `CHK("done", 1'b1, done)
        `CHK("count", ecnt, res.count)
        `CHK("timed_out", abort, res.timed_out)
        gp_i[6] = 1'b0;
        cfg = c;
    endtask
    task automatic t_refuse();
        cfg = mk(1'b1, 1'b0, 5'h14, 8'h00);
        start_i = 1'b1;
        tick();
        start_i = 1'b0;
        tick();
        `CHK("busy", 1'b0, busy)
    endtask
    task automatic t_rates();
        logic [4:0] codes [4] = '{5'h14, 5'h0a, 5'h01, 5'h00};
        logic       b;
        for (int j = 0; j < 4; j++) begin
            b = j[0];
            wrb(5'h00, {~b, 7'h55});
            run(mk(1'b1, 1'b0, codes[j], 8'h01), {b, 15'h0}, 0, 1'b0, 8'h01);
            `CHK("rx", ~b, far_rx[0])
            chk_buf(5'h00, {b, 7'h00}, 8'h80);
        end
    endtask
    task automatic t_burst();
        wrb(5'h00, 8'h5a);
        wrb(5'h01, 8'hc3);
        run(mk(1'b1, 1'b1, 5'h0a, 8'h0c), 16'h9e70, 0, 1'b0, 8'h0c);
        `CHK("rx", 12'h5ac, far_rx[11:0])
        chk_buf(5'h00, 8'h9e, 8'hff);
        chk_buf(5'h01, 8'h70, 8'hf0);
    endtask
    task automatic t_slave();
        wrb(5'h00, 8'h3c);
        wrb(5'h01, 8'h40);
        run(mk(1'b0, 1'b0, 5'h00, 8'h0a), 16'ha5c0, 10, 1'b0, 8'h0a);
        `CHK("rx", 10'h0f1, far_rx[9:0])
        chk_buf(5'h00, 8'ha5, 8'hff);
        chk_buf(5'h01, 8'hc0, 8'hc0);
    endtask
    task automatic t_abort();
        wrb(5'h00, 8'hf0);
        run(mk(1'b0, 1'b1, 5'h00, 8'h10), 16'h6800, 5, 1'b1, 8'h05);
        `CHK("rx", 5'h1e, far_rx[4:0])
        chk_buf(5'h00, 8'h68, 8'hf8);
    endtask
    initial begin
        n_errors = 0;
        compares = 0;
        arst_n_i = 1'b0;
        start_i = 1'b0;
        cfg = '0;
        wr_en = 1'b0;
        wa = 5'h00;
        wd = 8'h00;
        ra = 5'h00;
        gp_i = 8'hbf;
        repeat (4) @(posedge clock_i);
        #1;
        arst_n_i = 1'b1;
        t_refuse();
        t_rates();
        // each slave run follows a master run that idles at the slave's idle level,
        // so the synchronised clock shows no false active level at start
        t_slave();
        t_burst();
        t_abort();
        stop_test();
    end
    // about 22k cycles expected, so 60k cycles means a hang
    initial begin
        #600000;
        n_errors++;
        stop_test();
    end
endmodule
